// ### design/edge_detect.sv
// Rise and fall detector for a signal already synchronous to mclk
`timescale 1ns/1ps

module edge_detect #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic last_ff;
  logic nxt_last;

  always_comb begin
    nxt_last = level_i;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      last_ff <= RESET_LEVEL;
    end else begin
      last_ff <= nxt_last;
    end
  end

  assign rise_o = level_i & ~last_ff;
  assign fall_o = ~level_i & last_ff;

endmodule

// ### design/updn_control.sv
// Controlling end: makes the count clock, enable, direction and presets
`timescale 1ns/1ps
`include "updn_consts.svh"

module updn_control #(
  parameter int COUNT_W    = `UPDN_COUNT_W,
  parameter int HALF_CYC   = `UPDN_CLK_HALF_CYC,
  parameter int LOAD_CYC   = `UPDN_LOAD_LOW_CYC,
  parameter int RECOV_CYC  = `UPDN_RECOVER_CYC
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  updn_if.host                    pins,
  input  wire logic               run_i,
  input  wire logic               down_i,
  input  wire logic               carry_in_i,
  input  wire logic               load_req_i,
  input  wire logic [COUNT_W-1:0] load_value_i,
  output logic                    busy_o,
  output logic [COUNT_W-1:0]      count_o,
  output logic                    terminal_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (COUNT_W != `UPDN_COUNT_W || HALF_CYC < 2 || HALF_CYC > 255 ||
      LOAD_CYC < 1 || LOAD_CYC > 255 || RECOV_CYC < 1 || RECOV_CYC > 255) begin : g_bad_param
    $error("updn_control: parameter out of range");
  end

  localparam logic [7:0] HALF_M1  = 8'(HALF_CYC - 1);
  localparam logic [7:0] LOAD_M1  = 8'(LOAD_CYC - 1);
  localparam logic [7:0] RECOV_M1 = 8'(RECOV_CYC - 1);

  // ---------------------------------------------------------------
  // Sequencer and count clock divider
  // ---------------------------------------------------------------
  updn_pkg::ctl_state_t state_ff;
  updn_pkg::ctl_state_t nxt_state;
  logic [7:0]           div_ff;
  logic [7:0]           nxt_div;
  logic [7:0]           wait_ff;
  logic [7:0]           nxt_wait;
  logic                 cclk_ff;
  logic                 nxt_cclk;
  logic                 pl_n_ff;
  logic                 nxt_pl_n;
  logic [COUNT_W-1:0]   pval_ff;
  logic [COUNT_W-1:0]   nxt_pval;
  logic                 ce_n_ff;
  logic                 nxt_ce_n;
  logic                 down_ff;
  logic                 nxt_down;
  logic                 fall_now;

  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    nxt_pl_n  = pl_n_ff;
    nxt_pval  = pval_ff;
    nxt_div   = (div_ff == HALF_M1) ? 8'h00 : div_ff + 8'h01;
    nxt_cclk  = (div_ff == HALF_M1) ? ~cclk_ff : cclk_ff;
    fall_now  = (div_ff == HALF_M1) && cclk_ff;
    nxt_ce_n  = ce_n_ff;
    nxt_down  = down_ff;
    // Enable and direction move only at count clock fall: half a period of
    // setup before the next rise and of hold after the last.
    if (fall_now) begin
      // Enable term gated with preceding carry
      // Stopping this stage also silences its ripple clock
      nxt_ce_n = ~(run_i && carry_in_i && state_ff == updn_pkg::CTL_RUN);
      // Direction changes clear of the rise
      nxt_down = down_i;
    end
    unique case (state_ff)
      updn_pkg::CTL_IDLE,
      updn_pkg::CTL_RUN: begin
        if (load_req_i) begin
          nxt_state = updn_pkg::CTL_LOAD;
          nxt_pl_n  = 1'b0;
          nxt_pval  = load_value_i;
          nxt_wait  = LOAD_M1;
        end
      end
      updn_pkg::CTL_LOAD: begin
        if (wait_ff == 8'h00) begin
          nxt_state = updn_pkg::CTL_RECOVER;
          nxt_pl_n  = 1'b1;
          nxt_wait  = RECOV_M1;
        end else begin
          nxt_wait = wait_ff - 8'h01;
        end
      end
      updn_pkg::CTL_RECOVER: begin
        if (wait_ff == 8'h00) begin
          nxt_state = updn_pkg::CTL_RUN;
        end else begin
          nxt_wait = wait_ff - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= updn_pkg::CTL_IDLE;
      div_ff   <= 8'h00;
      wait_ff  <= 8'h00;
      cclk_ff  <= 1'b0;
      pl_n_ff  <= 1'b1;
      pval_ff  <= '0;
      ce_n_ff  <= 1'b1;
      down_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      div_ff   <= nxt_div;
      wait_ff  <= nxt_wait;
      cclk_ff  <= nxt_cclk;
      pl_n_ff  <= nxt_pl_n;
      pval_ff  <= nxt_pval;
      ce_n_ff  <= nxt_ce_n;
      down_ff  <= nxt_down;
    end
  end

  // ---------------------------------------------------------------
  // Status sampling
  // ---------------------------------------------------------------
  logic [COUNT_W-1:0] count_ff;
  logic               term_ff;
  logic               busy_ff;

  // Terminal flag only sampled, never a clock
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff <= '0;
      term_ff  <= 1'b0;
      busy_ff  <= 1'b0;
    end else begin
      count_ff <= pins.count_value;
      term_ff  <= pins.terminal_flag;
      busy_ff  <= (nxt_state == updn_pkg::CTL_LOAD) || (nxt_state == updn_pkg::CTL_RECOVER);
    end
  end

  // Low phase of HALF_CYC covers the device ripple delay
  assign pins.count_clock    = cclk_ff;
  assign pins.preset_load_n  = pl_n_ff;
  assign pins.preset_value   = pval_ff;
  assign pins.count_enable_n = ce_n_ff;
  assign pins.count_down     = down_ff;
  assign busy_o              = busy_ff;
  assign count_o             = count_ff;
  assign terminal_o          = term_ff;

endmodule

// ### design/updn_counter.sv
// Reversible binary counter with preset, terminal flag and ripple clock
`timescale 1ns/1ps
`include "updn_consts.svh"

// How it works
// - Binary counter, full modulus, both directions, synchronous
// - Low preset load copies preset value
// - Counts only on clock rise, enable low
// - Direction low counts up, high down
// - Controller changes enable/direction meeting setup/hold
// - Terminal flag: zero down, maximum up
// - Flag holds until state or direction changes
// - Terminal flag never used as a clock
// - Ripple clock low from clock fall to rise at terminal
// - Ripple clock held high while enable high
// - Ripple cascade clocks next stage from ripple
// - Shared clock low phase covers borrow ripple
// - Gated carry enable from preceding terminal flags
// - Terminal flag ignores own count enable

module updn_counter #(
  parameter int COUNT_W = `UPDN_COUNT_W
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  updn_if.device                  pins,
  output logic [COUNT_W-1:0]      count_o,
  output logic                    terminal_o,
  output logic                    loaded_o,
  output logic                    wrap_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (COUNT_W != `UPDN_COUNT_W) begin : g_bad_width
    $error("updn_counter: COUNT_W must match the pin width");
  end

  localparam logic [COUNT_W-1:0] TERM_UP   = COUNT_W'(`UPDN_TERM_UP);
  localparam logic [COUNT_W-1:0] TERM_DOWN = COUNT_W'(`UPDN_TERM_DOWN);
  localparam logic [COUNT_W-1:0] ONE       = COUNT_W'(1);

  // ---------------------------------------------------------------
  // Count clock edges
  // ---------------------------------------------------------------
  // Count clock is sampled like any other input, so its edges are seen one
  // mclk late; it must stay below half the mclk rate.
  logic clk_rise;
  logic clk_fall;

  edge_detect #(
    .RESET_LEVEL (1'b0)
  ) u_clk_edge (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .level_i (pins.count_clock),
    .rise_o  (clk_rise),
    .fall_o  (clk_fall)
  );

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  updn_pkg::count_mode_t mode;

  always_comb begin
    if (!pins.preset_load_n) begin
      mode = updn_pkg::MODE_LOAD;
    end else if (!pins.count_enable_n && clk_rise) begin
      mode = pins.count_down ? updn_pkg::MODE_DOWN : updn_pkg::MODE_UP;
    end else begin
      mode = updn_pkg::MODE_HOLD;
    end
  end

  // ---------------------------------------------------------------
  // Counter state
  // ---------------------------------------------------------------
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic               loaded_ff;
  logic               nxt_loaded;
  logic               wrap_ff;
  logic               nxt_wrap;

  always_comb begin
    nxt_count  = count_ff;
    nxt_loaded = loaded_ff;
    nxt_wrap   = 1'b0;
    unique case (mode)
      updn_pkg::MODE_LOAD: begin
        nxt_count  = pins.preset_value;
        nxt_loaded = 1'b1;
      end
      updn_pkg::MODE_UP: begin
        nxt_count = count_ff + ONE;
        nxt_wrap  = (count_ff == TERM_UP);
      end
      updn_pkg::MODE_DOWN: begin
        nxt_count = count_ff - ONE;
        nxt_wrap  = (count_ff == TERM_DOWN);
      end
      updn_pkg::MODE_HOLD: begin
        nxt_count = count_ff;
      end
    endcase
  end

  // Reset gives a known value only for simulation tidiness; software must
  // treat the count as meaningless until loaded_o rises.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff  <= `UPDN_COUNT_RST;
      loaded_ff <= 1'b0;
      wrap_ff   <= 1'b0;
    end else begin
      count_ff  <= nxt_count;
      loaded_ff <= nxt_loaded;
      wrap_ff   <= nxt_wrap;
    end
  end

  // ---------------------------------------------------------------
  // Terminal flag
  // ---------------------------------------------------------------
  logic tc_ff;
  logic nxt_tc;

  always_comb begin
    // Recomputed only from count and direction
    nxt_tc = pins.count_down ? (nxt_count == TERM_DOWN)
                             : (nxt_count == TERM_UP);
  end

  // Registered, so the flag is glitch free here even though the
  // far end must still not clock from it.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tc_ff <= 1'b0;
    end else begin
      tc_ff <= nxt_tc;
    end
  end

  // ---------------------------------------------------------------
  // Ripple clock
  // ---------------------------------------------------------------
  logic rc_n_ff;
  logic nxt_rc_n;

  always_comb begin
    if (pins.count_enable_n) begin
      nxt_rc_n = 1'b1;
    end else if (clk_rise) begin
      nxt_rc_n = 1'b1;
    // Low on clock fall at terminal
    end else if (clk_fall && tc_ff) begin
      nxt_rc_n = 1'b0;
    // Terminal lost, e.g. by preset or direction change
    end else if (!tc_ff) begin
      nxt_rc_n = 1'b1;
    end else begin
      nxt_rc_n = rc_n_ff;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_n_ff <= 1'b1;
    end else begin
      rc_n_ff <= nxt_rc_n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pins.count_value    = count_ff;
  assign pins.terminal_flag  = tc_ff;
  assign pins.ripple_clock_n = rc_n_ff;
  assign count_o             = count_ff;
  assign terminal_o          = tc_ff;
  assign loaded_o            = loaded_ff;
  assign wrap_o              = wrap_ff;

endmodule

// ### include/updn_consts.svh
// Constants for the reversible counter and its controlling end
`ifndef UPDN_CONSTS_SVH
`define UPDN_CONSTS_SVH

// Counter geometry
`define UPDN_COUNT_W        4
`define UPDN_TERM_DOWN      4'h0
`define UPDN_TERM_UP        4'hF
`define UPDN_COUNT_RST      4'h0

// Controller timing, in mclk cycles
`define UPDN_CLK_HALF_CYC   4
`define UPDN_LOAD_LOW_CYC   2
`define UPDN_RECOVER_CYC    2

`endif

// ### include/updn_if.sv
// Pin bundle between the counter and its controlling logic
`timescale 1ns/1ps
`include "updn_consts.svh"

interface updn_if;
  logic                      count_clock;
  logic                      preset_load_n;
  logic [`UPDN_COUNT_W-1:0]  preset_value;
  logic                      count_enable_n;
  logic                      count_down;
  logic [`UPDN_COUNT_W-1:0]  count_value;
  logic                      terminal_flag;
  logic                      ripple_clock_n;

  modport device (
    input  count_clock,
    input  preset_load_n,
    input  preset_value,
    input  count_enable_n,
    input  count_down,
    output count_value,
    output terminal_flag,
    output ripple_clock_n
  );

  modport host (
    output count_clock,
    output preset_load_n,
    output preset_value,
    output count_enable_n,
    output count_down,
    input  count_value,
    input  terminal_flag,
    input  ripple_clock_n
  );
endinterface

// ### include/updn_pkg.sv
// Types shared by both ends of the reversible counter
package updn_pkg;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_UP   = 2'b01,
    MODE_DOWN = 2'b10,
    MODE_LOAD = 2'b11
  } count_mode_t;

  typedef enum logic [1:0] {
    CTL_IDLE    = 2'b00,
    CTL_LOAD    = 2'b01,
    CTL_RECOVER = 2'b10,
    CTL_RUN     = 2'b11
  } ctl_state_t;

endpackage

// ### testbench/tb.sv
// Self-checking bench joining the controlling end and the counter
`timescale 1ns/1ps
`include "updn_consts.svh"

module tb;
  logic                     mclk_i       = 1'b0;
  logic                     rst_i        = 1'b1;
  logic                     run_i        = 1'b0;
  logic                     down_i       = 1'b0;
  logic                     carry_in_i   = 1'b1;
  logic                     load_req_i   = 1'b0;
  logic [`UPDN_COUNT_W-1:0] load_value_i = 4'h0;
  logic                     busy, loaded, wrap, dev_term, ctl_term, prev_clk, rise, fall, cnt;
  logic                     exp_flag, exp_rc, exp_wrap;
  logic [`UPDN_COUNT_W-1:0] dev_count, ctl_count, exp_count, nc;
  // Controller status copies lag the pins by one mclk
  logic [`UPDN_COUNT_W-1:0] exp_count_d;
  logic                     exp_flag_d;
  int                       fail_count   = 0;
  int                       check_count  = 0;
  int                       wraps        = 0;
  int                       rc_lows      = 0;

  always #5 mclk_i = ~mclk_i;

  updn_if bus ();
  updn_counter u_updn_counter (.mclk_i(mclk_i), .rst_i(rst_i), .pins(bus), .count_o(dev_count),
    .terminal_o(dev_term), .loaded_o(loaded), .wrap_o(wrap));
  updn_control u_updn_control (.mclk_i(mclk_i), .rst_i(rst_i), .pins(bus), .run_i(run_i), .down_i(down_i),
    .carry_in_i(carry_in_i), .load_req_i(load_req_i), .load_value_i(load_value_i), .busy_o(busy),
    .count_o(ctl_count), .terminal_o(ctl_term));
  updn_pins_asserts u_updn_pins_asserts (.mclk_i(mclk_i), .rst_i(rst_i), .count_clock(bus.count_clock),
    .preset_load_n(bus.preset_load_n), .preset_value(bus.preset_value), .count_enable_n(bus.count_enable_n),
    .count_down(bus.count_down), .count_value(bus.count_value), .terminal_flag(bus.terminal_flag),
    .ripple_clock_n(bus.ripple_clock_n));

  // ------------------------------------------------------------
  // Reference model of the pins
  // ------------------------------------------------------------
  function automatic logic flag_of(input logic [`UPDN_COUNT_W-1:0] c, input logic d);
    return d ? (c == `UPDN_TERM_DOWN) : (c == `UPDN_TERM_UP);
  endfunction

  assign rise = bus.count_clock & ~prev_clk;
  assign fall = ~bus.count_clock & prev_clk;
  assign cnt  = bus.preset_load_n & ~bus.count_enable_n & rise;
  assign nc   = !bus.preset_load_n ? bus.preset_value : !cnt ? exp_count :
                bus.count_down ? exp_count - 4'h1 : exp_count + 4'h1;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_clk <= 1'b0;
      exp_count <= `UPDN_COUNT_RST;
      exp_flag <= 1'b0;
      exp_rc <= 1'b1;
      exp_wrap <= 1'b0;
      exp_count_d <= `UPDN_COUNT_RST;
      exp_flag_d <= 1'b0;
    end else begin
      prev_clk <= bus.count_clock;
      exp_count_d <= exp_count;
      exp_flag_d <= exp_flag;
      exp_count <= nc;
      exp_flag <= flag_of(nc, bus.count_down);
      exp_wrap <= cnt & flag_of(exp_count, bus.count_down);
      if (fall && !bus.count_enable_n && exp_flag) begin
        exp_rc <= 1'b0;
      end else if (rise || bus.count_enable_n || !exp_flag) begin
        exp_rc <= 1'b1;
      end
    end
  end

  task automatic chk(input bit bad, input string m);
    check_count++;
    if (bad) begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      fail_count++;
    end
  endtask

  always @(negedge mclk_i) begin
    if (!rst_i) begin
      chk(bus.count_value !== exp_count, "count value");
      chk(dev_count !== exp_count, "count output");
      chk(dev_term !== exp_flag, "terminal output");
      chk(ctl_count !== exp_count_d, "controller count copy");
      chk(ctl_term !== exp_flag_d, "controller flag copy");
      chk(bus.terminal_flag !== exp_flag, "terminal flag");
      chk(bus.ripple_clock_n !== exp_rc, "ripple clock");
      chk(wrap !== exp_wrap, "wrap pulse");
      wraps += int'(exp_wrap);
      rc_lows += int'(!exp_rc);
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_idle();
    int n;
    // Let the request edge settle before looking at busy
    @(negedge mclk_i);
    chk(busy !== 1'b1, "busy not raised by load");
    for (n = 0; n < 40 && busy !== 1'b0; n++) begin
      @(negedge mclk_i);
    end
    if (busy !== 1'b0) begin
      chk(1'b1, "load never finished");
      complete_run();
    end
  endtask

  task automatic load(input logic [`UPDN_COUNT_W-1:0] v);
    @(posedge mclk_i);
    load_req_i <= 1'b1;
    load_value_i <= v;
    @(posedge mclk_i);
    load_req_i <= 1'b0;
    wait_idle();
  endtask

  initial begin
    repeat (100000) @(posedge mclk_i);
    chk(1'b1, "run limit reached");
    complete_run();
  end

  initial begin
    logic [`UPDN_COUNT_W-1:0] v;
    void'($urandom(32'hC86E));
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk(loaded !== 1'b0, "loaded before any load");
    // Extreme presets in both directions, counting inhibited
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      down_i <= i[0];
      load(i[1] ? 4'hF : 4'h0);
    end
    chk(loaded !== 1'b1, "loaded after load");
    // Second request while busy must be ignored
    @(posedge mclk_i);
    load_req_i <= 1'b1;
    load_value_i <= 4'h9;
    @(posedge mclk_i);
    load_value_i <= 4'h6;
    @(posedge mclk_i);
    load_req_i <= 1'b0;
    wait_idle();
    chk(bus.count_value !== 4'h9, "request taken while busy");
    $display("test presets done");
    // Two wrap corners, then random rounds with direction flipped midway
    for (int r = 0; r < 10; r++) begin
      v = (r == 0) ? 4'hE : (r == 1) ? 4'h1 : 4'($urandom_range(15));
      @(posedge mclk_i);
      down_i <= (r < 2) ? r[0] : 1'($urandom_range(1));
      carry_in_i <= (r < 2) ? 1'b1 : 1'($urandom_range(1));
      load(v);
      @(posedge mclk_i);
      run_i <= 1'b1;
      repeat (8 * `UPDN_CLK_HALF_CYC) @(posedge mclk_i);
      down_i <= ~down_i;
      repeat (6 * `UPDN_CLK_HALF_CYC) @(posedge mclk_i);
      run_i <= 1'b0;
      repeat (4 * `UPDN_CLK_HALF_CYC) @(negedge mclk_i);
      v = bus.count_value;
      repeat (8 * `UPDN_CLK_HALF_CYC) @(negedge mclk_i);
      chk(bus.count_value !== v, "count moved while inhibited");
      $display("test round %0d done", r);
    end
    chk(wraps == 0, "no wrap seen");
    chk(rc_lows == 0, "no ripple pulse seen");
    complete_run();
  end
endmodule

// ### testbench/updn_pins_asserts.sv
// Concurrent checks on the pins between controller and counter
`timescale 1ns/1ps
`include "updn_consts.svh"

module updn_pins_asserts (
  input wire logic                     mclk_i,
  input wire logic                     rst_i,
  input wire logic                     count_clock,
  input wire logic                     preset_load_n,
  input wire logic [`UPDN_COUNT_W-1:0] preset_value,
  input wire logic                     count_enable_n,
  input wire logic                     count_down,
  input wire logic [`UPDN_COUNT_W-1:0] count_value,
  input wire logic                     terminal_flag,
  input wire logic                     ripple_clock_n
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // Steps
  // ------------------------------------------------------------
  sequence s_count_rise;
    preset_load_n && !count_enable_n && $rose(count_clock);
  endsequence
  sequence s_ripple_arm;
    !count_enable_n && terminal_flag && $fell(count_clock);
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_load;
    !preset_load_n |=> count_value == $past(preset_value);
  endproperty
  property p_step;
    s_count_rise |=> count_value == ($past(count_down) ? $past(count_value) - 4'h1 : $past(count_value) + 4'h1);
  endproperty
  property p_hold;
    preset_load_n && (count_enable_n || !$rose(count_clock)) |=> $stable(count_value);
  endproperty
  // Flag follows the direction seen one edge earlier
  property p_flag;
    terminal_flag == ($past(count_down) ? count_value == `UPDN_TERM_DOWN : count_value == `UPDN_TERM_UP);
  endproperty
  property p_flag_keep;
    terminal_flag && $stable(count_down) |=> $stable(count_value) |-> terminal_flag;
  endproperty
  property p_rc_low;
    s_ripple_arm |=> !ripple_clock_n;
  endproperty
  property p_rc_high;
    $rose(count_clock) |=> ripple_clock_n;
  endproperty
  property p_rc_inhibit;
    count_enable_n |=> ripple_clock_n;
  endproperty
  property p_rc_cause;
    $fell(ripple_clock_n) |-> $past(terminal_flag) && !$past(count_enable_n) && !$past(count_clock);
  endproperty

  a_load: assert property (p_load)
    else $error("preset value not taken");
  a_step: assert property (p_step)
    else $error("count step wrong");
  a_hold: assert property (p_hold)
    else $error("count moved without a counted rise");
  a_flag: assert property (p_flag)
    else $error("terminal flag wrong");
  a_flag_keep: assert property (p_flag_keep)
    else $error("terminal flag dropped early");
  a_rc_low: assert property (p_rc_low)
    else $error("ripple clock not low after fall");
  a_rc_high: assert property (p_rc_high)
    else $error("ripple clock not high after rise");
  a_rc_inhibit: assert property (p_rc_inhibit)
    else $error("ripple clock low while inhibited");
  a_rc_cause: assert property (p_rc_cause)
    else $error("ripple clock low without cause");
endmodule
